/* File: pbfc_pci_model.sv */
// Model: PCI initiator making frames and parity errors
module pbfc_pci_model (
	input wire logic sys_clk,
	output logic     frame_n_i,
	output logic     devsel_n_i,
	output logic     perr_n_i,
	output logic     cmd_mem_io
);
	timeunit 1ns;
	timeprecision 1ns;
	initial {frame_n_i, devsel_n_i, perr_n_i, cmd_mem_io} = 4'he;
	// Released lines are pulled up, so they read high; cmd_mem_io is left low
	task automatic frame(input int n, input logic oth, input logic io);
		{frame_n_i, devsel_n_i, cmd_mem_io} = {1'b0, ~oth, io};
		repeat (n) @(posedge sys_clk);
		#1;
		{frame_n_i, devsel_n_i, cmd_mem_io} = 3'h6;
	endtask
	task automatic perr(input int n);
		perr_n_i = 0;
		repeat (n) @(posedge sys_clk);
		#1;
		perr_n_i = 1;
	endtask
endmodule

/* File: pbfc_pkg.sv */
// Package: offsets, fields, reset values and types of the bridge tuning registers
package pbfc_pkg;
	timeunit 1ns;
	timeprecision 1ns;

	// ----------------------------------------
	// Register offsets and reset values
	// ----------------------------------------
	localparam logic [7:0] TUNE_A_OFS   = 8'h41;
	localparam logic [7:0] TUNE_B_OFS   = 8'h42;
	localparam logic [7:0] TUNE_A_RESET = 8'h10;
	localparam logic [7:0] TUNE_B_RESET = 8'h28;
	localparam logic [7:0] READ_ZERO    = 8'h00;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int A_SINGLE_BEAT_BIT = 7;
	localparam int A_PERR_SERR_BIT   = 5;
	localparam int A_WBUF_BIT        = 4;
	localparam int A_DECODE_HI_BIT   = 2;
	localparam int A_DECODE_LO_BIT   = 1;
	localparam int B_DELAYED_BIT     = 5;
	localparam int B_NO_ARB_BIT      = 3;

	// ----------------------------------------
	// Decode timing
	// ----------------------------------------
	localparam logic [1:0] DECODE_DEFAULT = 2'h0;
	localparam logic [1:0] DECODE_SLOW    = 2'h1;
	localparam logic [2:0] SAMPLE_DEFAULT = 3'h4;
	localparam logic [2:0] SAMPLE_SLOW    = 3'h3;
	localparam logic [2:0] COUNT_ONE      = 3'h1;
	localparam logic [2:0] COUNT_ZERO     = 3'h0;

	// Posted write depth in bytes when write buffering is on
	localparam int WBUF_BYTES = 16;

	// ----------------------------------------
	// Types
	// ----------------------------------------
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} pbfc_cfg_req_s;

	typedef enum logic [1:0] {
		DEC_IDLE,
		DEC_COUNT,
		DEC_CLAIM,
		DEC_WAIT_END
	} pbfc_dec_state_e;

endpackage

/* File: pbfc_top.sv */
// Module: bridge tuning registers and the subtractive claim logic they steer
//
// Contract
// - Bit 7 set: split internal burst reads
// - Bit 5 set: drive SERR# while PERR# active
// - Bit 4 set: buffer sixteen write bytes
// - Decode 00 samples clock four, 01 three
// - Decode 1x: never claim unclaimed cycles
// - Second register bit 5 allows delayed transactions
// - Second register bit 3: buffer without arbitration
module pbfc_top (
	input  wire logic                  sys_clk,
	input  wire logic                  srst,
	input  wire logic                  ce,
	input  wire pbfc_pkg::pbfc_cfg_req_s cfg_req,
	output logic [7:0]                 cfg_rdata,
	input  wire logic                  xb_rd_burst,
	output logic                       pci_rd_burst,
	output logic                       wbuf_en,
	output logic                       delayed_txn_en,
	output logic                       buffer_without_arbitration,
	input  wire logic                  perr_n_i,
	output logic                       serr_n_o,
	output logic                       serr_oe_n,
	input  wire logic                  frame_n_i,
	input  wire logic                  devsel_n_i,
	input  wire logic                  cmd_mem_io,
	output logic                       devsel_n_o,
	output logic                       devsel_oe_n,
	output logic                       isa_fwd
);
	timeunit 1ns;
	timeprecision 1ns;


	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	logic [2:0] pin_meta_q;
	logic [2:0] pin_sync_q;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			pin_meta_q <= 3'h7;
			pin_sync_q <= 3'h7;
		end else if (ce) begin
			pin_meta_q <= {perr_n_i, frame_n_i, devsel_n_i};
			pin_sync_q <= pin_meta_q;
		end
	end

	logic perr_act;
	logic frame_act;
	logic devsel_act;
	assign perr_act   = ~pin_sync_q[2];
	assign frame_act  = ~pin_sync_q[1];
	assign devsel_act = ~pin_sync_q[0];

	// ----------------------------------------
	// Configuration registers
	// ----------------------------------------
	logic [7:0] tune_a_q, tune_a_d;
	logic [7:0] tune_b_q, tune_b_d;
	logic [7:0] rdata_q, rdata_d;

	// Write decode is shared by both tuning registers
	function automatic logic cfg_hit(
		input logic       strobe,
		input logic [7:0] addr,
		input logic [7:0] ofs
	);
		return strobe && (addr == ofs);
	endfunction

	// Whole bytes are stored; internal-use bits are kept by software read-modify-write
	always_comb begin
		tune_a_d = tune_a_q;
		tune_b_d = tune_b_q;
		rdata_d  = rdata_q;
		if (cfg_hit(cfg_req.wr, cfg_req.addr, pbfc_pkg::TUNE_A_OFS)) begin
			tune_a_d = cfg_req.wdata;
		end
		if (cfg_hit(cfg_req.wr, cfg_req.addr, pbfc_pkg::TUNE_B_OFS)) begin
			tune_b_d = cfg_req.wdata;
		end
		if (cfg_req.rd) begin
			case (cfg_req.addr)
				pbfc_pkg::TUNE_A_OFS: rdata_d = tune_a_q;
				pbfc_pkg::TUNE_B_OFS: rdata_d = tune_b_q;
				default:              rdata_d = pbfc_pkg::READ_ZERO;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			tune_a_q <= pbfc_pkg::TUNE_A_RESET;
			tune_b_q <= pbfc_pkg::TUNE_B_RESET;
			rdata_q  <= pbfc_pkg::READ_ZERO;
		end else if (ce) begin
			tune_a_q <= tune_a_d;
			tune_b_q <= tune_b_d;
			rdata_q  <= rdata_d;
		end
	end

	// ----------------------------------------
	// Steering outputs
	// ----------------------------------------
	logic burst_q, burst_d;
	logic wbuf_q, wbuf_d;
	logic dly_q, dly_d;
	logic noarb_q, noarb_d;
	logic serr_oe_n_q, serr_oe_n_d;

	always_comb begin
		burst_d     = xb_rd_burst & ~tune_a_q[pbfc_pkg::A_SINGLE_BEAT_BIT];
		wbuf_d      = tune_a_q[pbfc_pkg::A_WBUF_BIT];
		dly_d       = tune_b_q[pbfc_pkg::B_DELAYED_BIT];
		noarb_d     = tune_b_q[pbfc_pkg::B_NO_ARB_BIT];
		serr_oe_n_d = ~(tune_a_q[pbfc_pkg::A_PERR_SERR_BIT] & perr_act);
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			burst_q     <= 1'b0;
			wbuf_q      <= 1'b0;
			dly_q       <= 1'b0;
			noarb_q     <= 1'b0;
			serr_oe_n_q <= 1'b1;
		end else if (ce) begin
			burst_q     <= burst_d;
			wbuf_q      <= wbuf_d;
			dly_q       <= dly_d;
			noarb_q     <= noarb_d;
			serr_oe_n_q <= serr_oe_n_d;
		end
	end

	// ----------------------------------------
	// Subtractive claim
	// ----------------------------------------
	pbfc_pkg::pbfc_dec_state_e st_q, st_d;
	logic [2:0] cnt_q, cnt_d;
	logic       dev_oe_n_q, dev_oe_n_d;
	logic       fwd_q, fwd_d;
	logic [1:0] decode_mode;
	logic [2:0] sample_at;

	assign decode_mode = {tune_a_q[pbfc_pkg::A_DECODE_HI_BIT], tune_a_q[pbfc_pkg::A_DECODE_LO_BIT]};
	// Clock counts run from the synchronised FRAME# edge, so all agents see the same delay
	assign sample_at = (decode_mode == pbfc_pkg::DECODE_SLOW) ? pbfc_pkg::SAMPLE_SLOW
	                                                          : pbfc_pkg::SAMPLE_DEFAULT;

	always_comb begin
		st_d       = st_q;
		cnt_d      = cnt_q;
		dev_oe_n_d = dev_oe_n_q;
		fwd_d      = 1'b0;
		case (st_q)
			pbfc_pkg::DEC_IDLE: begin
				if (frame_act) begin
					cnt_d = pbfc_pkg::COUNT_ONE;
					st_d  = pbfc_pkg::DEC_COUNT;
				end
			end
			pbfc_pkg::DEC_COUNT: begin
				// Counting goes on after FRAME# rises: one-phase frames drop it early
				cnt_d = 3'(cnt_q + pbfc_pkg::COUNT_ONE);
				if (decode_mode[1] || devsel_act || !cmd_mem_io) begin
					st_d = pbfc_pkg::DEC_WAIT_END;
				end else if (cnt_d == sample_at) begin
					st_d = pbfc_pkg::DEC_CLAIM;
				end
			end
			pbfc_pkg::DEC_CLAIM: begin
				if (!devsel_act) begin
					dev_oe_n_d = 1'b0;
					fwd_d      = 1'b1;
				end
				st_d = pbfc_pkg::DEC_WAIT_END;
			end
			pbfc_pkg::DEC_WAIT_END: begin
				// Hold the claim until the initiator ends the frame
				if (!frame_act) begin
					dev_oe_n_d = 1'b1;
					cnt_d      = pbfc_pkg::COUNT_ZERO;
					st_d       = pbfc_pkg::DEC_IDLE;
				end
			end
			default: begin
				dev_oe_n_d = 1'b1;
				st_d       = pbfc_pkg::DEC_IDLE;
			end
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			st_q       <= pbfc_pkg::DEC_IDLE;
			cnt_q      <= pbfc_pkg::COUNT_ZERO;
			dev_oe_n_q <= 1'b1;
			fwd_q      <= 1'b0;
		end else if (ce) begin
			st_q       <= st_d;
			cnt_q      <= cnt_d;
			dev_oe_n_q <= dev_oe_n_d;
			fwd_q      <= fwd_d;
		end
	end

	assign cfg_rdata                  = rdata_q;
	assign pci_rd_burst               = burst_q;
	assign wbuf_en                    = wbuf_q;
	assign delayed_txn_en             = dly_q;
	assign buffer_without_arbitration = noarb_q;
	// Open-drain style: data low, enable decides
	assign serr_n_o                   = 1'b0;
	assign serr_oe_n                  = serr_oe_n_q;
	assign devsel_n_o                 = 1'b0;
	assign devsel_oe_n                = dev_oe_n_q;
	assign isa_fwd                    = fwd_q;

endmodule

/* File: pbfc_top_asserts.sv */
// Checker: port timing of the bridge tuning block
module pbfc_top_asserts (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic xb_rd_burst,
	input wire logic pci_rd_burst,
	input wire logic perr_n_i,
	input wire logic serr_oe_n,
	input wire logic frame_n_i,
	input wire logic devsel_n_i,
	input wire logic cmd_mem_io,
	input wire logic devsel_oe_n,
	input wire logic isa_fwd
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (srst);
	burst_pass_a: assert property (pci_rd_burst |-> $past(xb_rd_burst))
		else $error("burst without request");
	serr_cause_a: assert property (!serr_oe_n |-> !$past(perr_n_i, 3))
		else $error("serr without perr");
	fwd_claim_a: assert property (isa_fwd |-> $fell(devsel_oe_n))
		else $error("forward without claim");
	fwd_pulse_a: assert property (isa_fwd |=> !isa_fwd)
		else $error("forward too long");
	claim_late_a: assert property ($fell(devsel_oe_n) |-> !$past(frame_n_i, 6))
		else $error("claim too early");
	claim_free_a: assert property ($fell(devsel_oe_n) |-> $past(devsel_n_i, 3) && cmd_mem_io)
		else $error("claim of taken cycle");
	claim_hold_a: assert property (!devsel_oe_n && !frame_n_i |=> !devsel_oe_n)
		else $error("claim dropped");
	// Pin sync adds two edges and the state register a third before release
	claim_end_a: assert property ($rose(frame_n_i) |-> ##[1:5] devsel_oe_n)
		else $error("claim held");
	cover property (isa_fwd);
	cover property (!serr_oe_n);
	cover property (pci_rd_burst);
endmodule

/* File: testbench.sv */
// Testbench: registers, steering, parity forwarding and claiming
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0;
	logic srst = 1;
	logic ce = 1;
	logic xb_rd_burst = 0;
	logic pci_rd_burst, wbuf_en, delayed_txn_en, buffer_without_arbitration, serr_n_o;
	logic perr_n_i, serr_oe_n, frame_n_i, devsel_n_i, cmd_mem_io, devsel_n_o, devsel_oe_n, isa_fwd;
	logic [7:0] cfg_rdata;
	int   bad_count = 0;
	int   samples_checked = 0;
	pbfc_pkg::pbfc_cfg_req_s cfg_req = '0;
	always #5 sys_clk = ~sys_clk;
	pbfc_pci_model pm (.sys_clk, .frame_n_i, .devsel_n_i, .perr_n_i, .cmd_mem_io);
	pbfc_top DUT (.sys_clk, .srst, .ce, .cfg_req, .cfg_rdata, .xb_rd_burst, .pci_rd_burst,
		.wbuf_en, .delayed_txn_en, .buffer_without_arbitration, .perr_n_i, .serr_n_o,
		.serr_oe_n, .frame_n_i, .devsel_n_i, .cmd_mem_io, .devsel_n_o, .devsel_oe_n, .isa_fwd);
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		cfg_req = '{1'b1, 1'b0, a, d};
		tick(1);
		// One idle edge keeps the next request out of this time step
		cfg_req = '0;
		tick(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		cfg_req = '{1'b0, 1'b1, a, 8'h00};
		tick(1);
		cfg_req = '0;
		check(cfg_rdata, exp);
		tick(1);
	endtask
	task automatic final_report;
		$display("checked %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic t_regs;
		rd(8'h41, 8'h10);
		rd(8'h42, 8'h28);
		check({5'h00, wbuf_en, delayed_txn_en, buffer_without_arbitration}, 8'h07);
		wr(8'h43, 8'hff);
		rd(8'h43, 8'h00);
		xb_rd_burst = 1;
		// Internal-use bits stay at their reset zeros
		wr(8'h42, 8'h00);
		wr(8'h41, 8'h80);
		rd(8'h41, 8'h80);
		check({6'h00, pci_rd_burst, wbuf_en}, 8'h00);
		check({6'h00, delayed_txn_en, buffer_without_arbitration}, 8'h00);
		wr(8'h41, 8'h10);
		wr(8'h42, 8'h28);
		check({7'h00, pci_rd_burst}, 8'h01);
		$display("regs test end");
	endtask
	task automatic t_serr(input logic en);
		wr(8'h41, {2'h0, en, 5'h10});
		fork
			pm.perr(8);
			tick(6);
		join_any
		check({6'h00, serr_n_o, serr_oe_n}, {6'h00, 1'b0, ~en});
		tick(8);
		check({7'h00, serr_oe_n}, 8'h01);
		$display("serr test end");
	endtask
	task automatic t_claim(input logic [1:0] m, input logic oth, input logic io, input int exp);
		int n;
		n = 0;
		wr(8'h41, {5'h02, m, 1'b0});
		fork
			pm.frame(12, oth, io);
			for (int i = 1; i <= 12 && n == 0; i++) begin
				tick(1);
				if (devsel_oe_n === 1'b0) begin
					n = i;
					check({6'h00, devsel_n_o, isa_fwd}, 8'h01);
				end
			end
		join
		check(n[7:0], exp[7:0]);
		if (exp != 0 && n == 0)
			final_report;
		tick(6);
		check({7'h00, devsel_oe_n}, 8'h01);
		$display("claim test end");
	endtask
	task automatic t_freeze;
		// With ce low neither the write nor the read may be taken
		ce = 0;
		wr(8'h41, 8'h80);
		rd(8'h42, 8'h80);
		ce = 1;
		rd(8'h41, 8'h10);
		$display("freeze test end");
	endtask
	task automatic t_reset;
		wr(8'h41, 8'h80);
		wr(8'h42, 8'h00);
		srst = 1;
		tick(2);
		srst = 0;
		rd(8'h41, 8'h10);
		rd(8'h42, 8'h28);
		check({6'h00, pci_rd_burst, wbuf_en}, 8'h03);
		check({6'h00, delayed_txn_en, buffer_without_arbitration}, 8'h03);
		check({6'h00, serr_oe_n, devsel_oe_n}, 8'h03);
		$display("reset test end");
	endtask
	initial begin
		tick(20);
		srst = 0;
		t_regs;
		t_freeze;
		t_serr(1'b1);
		t_serr(1'b0);
		// The claim lands on the seventh edge after FRAME# is driven low in mode 00
		t_claim(2'h0, 1'b0, 1'b1, 7);
		t_claim(2'h1, 1'b0, 1'b1, 6);
		t_claim(2'h2, 1'b0, 1'b1, 0);
		t_claim(2'h0, 1'b1, 1'b1, 0);
		t_claim(2'h0, 1'b0, 1'b0, 0);
		t_reset;
		final_report;
	end
endmodule
bind pbfc_top pbfc_top_asserts chk (.sys_clk, .srst, .xb_rd_burst, .pci_rd_burst, .perr_n_i,
	.serr_oe_n, .frame_n_i, .devsel_n_i, .cmd_mem_io, .devsel_oe_n, .isa_fwd);
